// [rtl/ipd_cfg.svh]
// Constants for the idle and power-down controller
`ifndef IPD_CFG_SVH
`define IPD_CFG_SVH

// ****************************************************************
// APB register map (byte addresses)
// ****************************************************************
`define IPD_ADDR_PWR_CFG 8'h00
`define IPD_ADDR_AUX_CTL 8'h04
`define IPD_ADDR_STATUS 8'h08

// ****************************************************************
// Field positions in the power configuration register
// ****************************************************************
`define IPD_BIT_IDLE 0
`define IPD_BIT_PDOWN 1
`define IPD_BIT_GF0 2
`define IPD_BIT_GF1 3

// ****************************************************************
// Field positions in the aux control register
// ****************************************************************
`define IPD_BIT_BOOT_MAP 0
`define IPD_BIT_KEY_POL 1

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define IPD_PWR_CFG_RST 8'h00
`define IPD_KEY_WAKE_CYCLES 1024
`define IPD_RST_WINDOW_CYCLES 4
`define IPD_SYNC_STAGES 2

`endif

// [rtl/ipd_clk_gate.sv]
// Glitch-free latch-based clock gate
`timescale 1ns/1ps
`default_nettype none

module ipd_clk_gate
(
   input wire logic clk_in,
   input wire logic enable,
   output logic clk_out
);

   logic en_latch;

   // ****************************************************************
   // Enable only moves while the clock is low, so no runt pulses
   // ****************************************************************
   always_latch
   begin
      if (!clk_in)
         en_latch <= enable;
   end

   assign clk_out = clk_in & en_latch;

endmodule : ipd_clk_gate

`default_nettype wire

// [rtl/ipd_ctrl.sv]
// Idle and power-down controller with APB register access
//
// Chosen here: the APB register port and the register offsets.
`include "ipd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Idle gates the CPU clock low, peripherals keep running.
// - Idle freezes CPU, so PC, PSW, registers and RAM keep values.
// - Writing idle bit stops CPU right after that write.
// - Idle plus power-down together enters power-down, never idle after.
// - Enabled interrupt in idle clears idle bit, restores CPU clock.
// - Two writable general flags survive idle mode.
// - Reset pin high clears idle bit asynchronously.
// - After reset wake CPU runs briefly, then internal reset to start.
// - During that brief window RAM access blocked, ports allowed.
// - Power-down halts oscillator and freezes all clocks.
// - Power-down preserves PC, PSW, registers and RAM.
// - Writing power-down bit makes that write the last executed.
// - Power-down exits only on ext irq zero/one, keypad zero, reset.
// - Keypad wake level selectable high or low.
// - Interrupt wake clears power-down bit, restarts oscillator, clocks.
// - Boot map enable loaded from inverted boot jump fuse on first clock after reset release.
// - Keypad wake waits 1024 cycles; ext irq wake waits for release.
// - Ext irq wake resumes only after the input deasserts; a keypad hit in the same cycle takes the keypad count instead, ext ignored.
// - Reset pin high clears power-down bit, restarts clocks first.
module ipd_ctrl
#(
   parameter int KEY_WAKE_CYCLES = `IPD_KEY_WAKE_CYCLES,
   parameter int RST_WINDOW_CYCLES = `IPD_RST_WINDOW_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_irq_zero_input,
   input wire logic ext_irq_one_input,
   input wire logic keypad_wake_input_zero,
   input wire logic irq_pending,
   input wire logic boot_jump_fuse,
   output logic osc_enable,
   output logic cpu_clk_enable,
   output logic per_clk_enable,
   output logic cpu_wake_pulse,
   output logic ram_block,
   output logic internal_reset
);
   import ipd_pkg::*;

   localparam int KW = $clog2(KEY_WAKE_CYCLES + 1);
   localparam int RW = $clog2(RST_WINDOW_CYCLES + 1);
   localparam logic [KW-1:0] KEY_LAST = KW'(KEY_WAKE_CYCLES - 1);
   localparam logic [RW-1:0] RST_LAST = RW'(RST_WINDOW_CYCLES - 1);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   if (KEY_WAKE_CYCLES < 1)
      $error("KEY_WAKE_CYCLES must be at least one");
   if (RST_WINDOW_CYCLES < 1)
      $error("RST_WINDOW_CYCLES must be at least one");

   // ****************************************************************
   // Declarations
   // ****************************************************************
   ipd_state_t state_r, state_nxt;
   logic idle_request_bit_r, powerdown_request_bit_r;
   logic general_flag_zero_r, general_flag_one_r;
   logic boot_map_enable_r, key_pol_r, fuse_taken_r;
   logic [KW-1:0] key_cnt_r;
   logic [RW-1:0] rst_cnt_r;
   logic rst_win_r;
   logic [2:0] pins_sync;
   logic ext0_s, ext1_s, key_s;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   ipd_sync #(.WIDTH(3)) u_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({keypad_wake_input_zero, ext_irq_one_input,
                 ext_irq_zero_input}),
      .sync_out(pins_sync)
   );

   assign ext0_s = pins_sync[0];
   assign ext1_s = pins_sync[1];
   assign key_s = pins_sync[2];

   // ****************************************************************
   // Glitch-free gates for the CPU and peripheral clocks
   // ****************************************************************
   // Enables come from flops, so each gate sees a clean level;
   // the gated taps are left open here and picked up at chip level
   ipd_clk_gate u_cpu_gate
   (
      .clk_in(pclk),
      .enable(cpu_clk_enable),
      .clk_out()
   );

   ipd_clk_gate u_per_gate
   (
      .clk_in(pclk),
      .enable(per_clk_enable),
      .clk_out()
   );

   // ****************************************************************
   // APB decode
   // ****************************************************************
   wire access = psel & penable & pready; // Lands only at the answer edge
   wire wr = access & pwrite;
   wire hit_cfg = paddr == `IPD_ADDR_PWR_CFG;
   wire hit_aux = paddr == `IPD_ADDR_AUX_CTL;
   wire hit_stat = paddr == `IPD_ADDR_STATUS;
   wire hit_any = hit_cfg | hit_aux | hit_stat;
   wire wr_cfg = wr & hit_cfg;
   wire wr_aux = wr & hit_aux;
   wire set_idle = wr_cfg & pwdata[`IPD_BIT_IDLE];
   wire set_pd = wr_cfg & pwdata[`IPD_BIT_PDOWN];

   // Wake conditions
   wire key_hit = key_s ^ ~key_pol_r;
   wire ext_hit = ext0_s | ext1_s;
   wire pd_wake = ext_hit | key_hit;
   wire idle_wake = irq_pending;
   wire key_done = key_cnt_r == KEY_LAST;

   wire [31:0] cfg_word = {28'h0000000, general_flag_one_r,
      general_flag_zero_r, powerdown_request_bit_r, idle_request_bit_r};
   wire [31:0] aux_word = {30'h00000000, key_pol_r, boot_map_enable_r};
   wire [31:0] stat_word = {28'h0000000, rst_win_r, 3'(state_r)};
   wire [31:0] rd_mux = hit_cfg ? cfg_word :
                        hit_aux ? aux_word :
                        hit_stat ? stat_word : 32'h00000000;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         IPD_RUN:
            if (set_pd)
               state_nxt = IPD_PDOWN;
            else if (set_idle)
               state_nxt = IPD_IDLE;
         IPD_IDLE:
            if (idle_wake)
               state_nxt = IPD_RUN;
         IPD_PDOWN:
            if (pd_wake)
               state_nxt = key_hit ? IPD_KEY_WAIT : IPD_EXT_WAIT;
         IPD_KEY_WAIT:
            if (key_done)
               state_nxt = IPD_RUN;
         IPD_EXT_WAIT:
            if (!ext_hit)
               state_nxt = IPD_RUN;
         default:
            state_nxt = IPD_RUN;
      endcase
   end

   // ****************************************************************
   // State and request bits; reset pin clears them asynchronously
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= IPD_RUN;
         idle_request_bit_r <= 1'b0;
         powerdown_request_bit_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         idle_request_bit_r <= state_nxt == IPD_IDLE;
         powerdown_request_bit_r <= state_nxt == IPD_PDOWN;
      end
   end

   // ****************************************************************
   // General flags; only software changes them, so idle keeps them
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         general_flag_zero_r <= 1'b0;
         general_flag_one_r <= 1'b0;
      end
      else if (wr_cfg)
      begin
         general_flag_zero_r <= pwdata[`IPD_BIT_GF0];
         general_flag_one_r <= pwdata[`IPD_BIT_GF1];
      end
   end

   // ****************************************************************
   // Boot map: fuse caught by a clocked load after release
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fuse_taken_r <= 1'b0;
         boot_map_enable_r <= 1'b0;
         key_pol_r <= 1'b0;
      end
      else
      begin
         fuse_taken_r <= 1'b1;
         if (!fuse_taken_r)
            boot_map_enable_r <= ~boot_jump_fuse;
         else if (wr_aux)
            boot_map_enable_r <= pwdata[`IPD_BIT_BOOT_MAP];
         if (wr_aux)
            key_pol_r <= pwdata[`IPD_BIT_KEY_POL];
      end
   end

   // ****************************************************************
   // Oscillator restart counter for keypad wake
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         key_cnt_r <= '0;
      else if (state_r == IPD_KEY_WAIT)
         key_cnt_r <= KW'(key_cnt_r + 1'b1);
      else
         key_cnt_r <= '0;
   end

   // ****************************************************************
   // Short window after reset wake: CPU runs, RAM is blocked
   // Counted in the pclk domain from release; reset already holds the window open.
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rst_cnt_r <= '0;
         rst_win_r <= 1'b1;
      end
      else if (rst_win_r)
      begin
         rst_cnt_r <= RW'(rst_cnt_r + 1'b1);
         if (rst_cnt_r == RST_LAST)
            rst_win_r <= 1'b0;
      end
   end

   // ****************************************************************
   // Registered outputs; clock enables drive the glitch-free gates
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         osc_enable <= 1'b1;
         cpu_clk_enable <= 1'b1;
         per_clk_enable <= 1'b1;
         cpu_wake_pulse <= 1'b0;
         ram_block <= 1'b1;
         internal_reset <= 1'b0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         // Oscillator back as soon as any wake is seen
         osc_enable <= state_nxt != IPD_PDOWN;
         // CPU frozen in idle, power-down and wake waits
         cpu_clk_enable <= state_nxt == IPD_RUN;
         per_clk_enable <= state_nxt == IPD_RUN ||
            state_nxt == IPD_IDLE;
         cpu_wake_pulse <= state_r != IPD_RUN && state_nxt == IPD_RUN;
         ram_block <= rst_win_r;
         internal_reset <= rst_win_r & (rst_cnt_r == RST_LAST);
         // No-wait-state slave; answer on every access
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit_any;
         if (psel & ~penable & ~pwrite)
            prdata <= rd_mux;
      end
   end

endmodule : ipd_ctrl

`default_nettype wire

// [rtl/ipd_pkg.sv]
// Types shared by the idle and power-down controller
`default_nettype none

package ipd_pkg;

   // Power states of the controller
   typedef enum logic [2:0]
   {
      IPD_RUN = 3'b000,
      IPD_IDLE = 3'b001,
      IPD_PDOWN = 3'b010,
      IPD_KEY_WAIT = 3'b011,
      IPD_EXT_WAIT = 3'b100
   } ipd_state_t;

endpackage : ipd_pkg

`default_nettype wire

// [rtl/ipd_sync.sv]
// Two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none

module ipd_sync
#(
   parameter int WIDTH = 1
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_r;

   // ****************************************************************
   // First stage read only by the second
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_r <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule : ipd_sync

`default_nettype wire

// [sim/ipd_cpu_model.sv]
// Behavioural interrupt source on the CPU side
`timescale 1ns/1ps
`default_nettype none

module ipd_cpu_model
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic req,
   input wire logic [3:0] lat,
   input wire logic cpu_clk_enable,
   output logic irq_pending
);
   logic [3:0] wait_r;

   // Pending rises lat+1 cycles after a request while the cpu is stopped;
   // it falls when the cpu clock returns, as a serviced source would
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wait_r <= 4'h0;
         irq_pending <= 1'b0;
      end
      else if (!req || cpu_clk_enable)
      begin
         wait_r <= 4'h0;
         irq_pending <= 1'b0;
      end
      else if (wait_r == lat)
         irq_pending <= 1'b1;
      else
         wait_r <= wait_r + 4'h1;
   end
endmodule : ipd_cpu_model
`default_nettype wire

// [sim/ipd_ctrl_assertions.sv]
// Port-level checks of the idle and power-down controller
`include "ipd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module ipd_ctrl_assertions
#(
   parameter int KEY_WAKE_CYCLES = `IPD_KEY_WAKE_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic ext_irq_zero_input,
   input wire logic ext_irq_one_input,
   input wire logic irq_pending,
   input wire logic osc_enable,
   input wire logic cpu_clk_enable,
   input wire logic per_clk_enable,
   input wire logic ram_block,
   input wire logic internal_reset
);
   localparam int KEY_LO = KEY_WAKE_CYCLES;
   localparam int KEY_HI = KEY_WAKE_CYCLES + 4;
   logic cfg_wr;
   logic ext_any;
   logic key_r;
   logic [15:0] wake_cnt_r;

   // Write to the power word taken at this edge
   assign cfg_wr = psel && penable && pready && pwrite &&
      paddr == `IPD_ADDR_PWR_CFG;
   assign ext_any = ext_irq_zero_input || ext_irq_one_input;

   // Cycles since the oscillator restarted; no ext pin means a key wake
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wake_cnt_r <= 16'h0000;
         key_r <= 1'b0;
      end
      else
      begin
         wake_cnt_r <= osc_enable ? wake_cnt_r + 16'h0001 : 16'h0000;
         if ($rose(osc_enable))
            key_r <= !ext_any;
         else if (cpu_clk_enable)
            key_r <= 1'b0;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_idle_gate: assert property (
      cfg_wr && pwdata[0] && !pwdata[1] |->
      ##[1:2] !cpu_clk_enable && per_clk_enable && osc_enable)
      else $error("idle write did not gate the cpu clock alone");
   a_pd_stop: assert property (
      cfg_wr && pwdata[1] |-> ##[1:3] !osc_enable)
      else $error("power-down write did not stop the oscillator");
   a_osc_pd: assert property (
      !osc_enable |-> !cpu_clk_enable && !per_clk_enable)
      else $error("a clock runs while the oscillator is off");
   a_idle_wake: assert property (
      !cpu_clk_enable && per_clk_enable && irq_pending |->
      ##[1:3] cpu_clk_enable)
      else $error("pending interrupt did not end idle");
   a_reset_on: assert property (
      disable iff (1'b0)
      !presetn |-> osc_enable && cpu_clk_enable && per_clk_enable)
      else $error("clocks not restored under reset");
   a_ext_hold: assert property (
      !cpu_clk_enable && ext_any |=> !cpu_clk_enable)
      else $error("cpu resumed while an ext pin is held");
   a_key_wait: assert property (
      $rose(cpu_clk_enable) && key_r |->
      wake_cnt_r >= KEY_LO && wake_cnt_r <= KEY_HI)
      else $error("key wake restart count wrong");
   a_rst_block: assert property (
      $rose(presetn) |-> ram_block until_with internal_reset)
      else $error("ram unblocked before internal reset");
   a_rst_end: assert property (
      $rose(presetn) |-> ##[2:7] internal_reset ##1
      !ram_block && !internal_reset)
      else $error("internal reset window wrong");
endmodule : ipd_ctrl_assertions

bind ipd_ctrl ipd_ctrl_assertions
#(
   .KEY_WAKE_CYCLES(KEY_WAKE_CYCLES)
)
i_chk
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .ext_irq_zero_input(ext_irq_zero_input),
   .ext_irq_one_input(ext_irq_one_input), .irq_pending(irq_pending),
   .osc_enable(osc_enable), .cpu_clk_enable(cpu_clk_enable),
   .per_clk_enable(per_clk_enable), .ram_block(ram_block),
   .internal_reset(internal_reset)
);
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the idle and power-down controller
`include "ipd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import ipd_pkg::*;
   localparam int KEY = 8;
   logic pclk = 1'b0;
   // Starts high so that driving it low at time zero is a reset edge
   logic presetn = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fuse = 1'b0;
   logic ext0 = 1'b0, ext1 = 1'b0, key = 1'b1, req = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0] lat = 4'h0;
   logic pready, pslverr, osc_enable, cpu_clk_enable, per_clk_enable;
   logic cpu_wake_pulse, ram_block, internal_reset, irq_pending;
   logic [64:0] exp_q[$];
   logic [64:0] ex;
   logic [1:0] f;
   int err_count = 0, comparisons = 0, n;

   always #5 pclk = ~pclk;

   ipd_ctrl #(.KEY_WAKE_CYCLES(KEY),
      .RST_WINDOW_CYCLES(`IPD_RST_WINDOW_CYCLES)) i_dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_irq_zero_input(ext0),
      .ext_irq_one_input(ext1), .keypad_wake_input_zero(key),
      .irq_pending(irq_pending), .boot_jump_fuse(fuse),
      .osc_enable(osc_enable), .cpu_clk_enable(cpu_clk_enable),
      .per_clk_enable(per_clk_enable), .cpu_wake_pulse(cpu_wake_pulse),
      .ram_block(ram_block), .internal_reset(internal_reset)
   );

   ipd_cpu_model i_cpu
   (
      .pclk(pclk), .presetn(presetn), .req(req), .lat(lat),
      .cpu_clk_enable(cpu_clk_enable), .irq_pending(irq_pending)
   );

   task automatic close_out;
      if (err_count == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out

   task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] s);
      comparisons++;
      if (s !== e)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, s);
      end
   endtask : chk

   // One APB transfer; the result is noted for the monitor to compare
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [31:0] e, input logic [31:0] m,
      input logic er);
      int t;
      exp_q.push_back({e, m, er});
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do
      begin
         @(posedge pclk);
         t++;
      end
      while (pready !== 1'b1 && t < 16);
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pready", 32'h1, {31'h0, pready});
      if (pready !== 1'b1)
         close_out();
   endtask : apb

   // Bounded wait for the oscillator or cpu enable to reach a level
   task automatic wait_for(input logic osc, input logic v, input int lim);
      n = 0;
      while ((osc ? osc_enable : cpu_clk_enable) !== v && n < lim)
      begin
         @(posedge pclk);
         n++;
      end
      chk("wait", {31'h0, v}, {31'h0, osc ? osc_enable : cpu_clk_enable});
      if ((osc ? osc_enable : cpu_clk_enable) !== v)
         close_out();
   endtask : wait_for

   // Completed transfers against the oldest note
   always @(posedge pclk)
      if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
      begin
         ex = exp_q.pop_front();
         chk("prdata", ex[64:33], prdata & ex[32:1]);
         chk("pslverr", {31'h0, ex[0]}, {31'h0, pslverr});
      end

   initial
   begin
      presetn <= 1'b0;
      fuse <= 1'($urandom(32'hFD0C9FB3));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      apb(1'b0, `IPD_ADDR_PWR_CFG, 32'h0, 32'h0, 32'hF, 1'b0);
      apb(1'b0, `IPD_ADDR_AUX_CTL, 32'h0, {31'h0, ~fuse}, 32'h1, 1'b0);
      apb(1'b0, `IPD_ADDR_STATUS, 32'h0, IPD_RUN, 32'hF, 1'b0);
      apb(1'b1, 8'h0C, $urandom, 32'h0, 32'h0, 1'b1);
      apb(1'b0, 8'h0C, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
      // Idle, woken by a pending interrupt; flags kept
      f = 2'($urandom);
      lat <= 4'($urandom_range(0, 7));
      apb(1'b1, `IPD_ADDR_PWR_CFG, {28'h0, f, 2'b01}, 32'h0, 32'h0, 1'b0);
      wait_for(1'b0, 1'b0, 8);
      chk("idle clocks", 32'h3, {30'h0, osc_enable, per_clk_enable});
      apb(1'b0, `IPD_ADDR_STATUS, 32'h0, IPD_IDLE, 32'h7, 1'b0);
      req <= 1'b1;
      wait_for(1'b0, 1'b1, 40);
      chk("cpu_wake_pulse", 32'h1, {31'h0, cpu_wake_pulse});
      req <= 1'b0;
      apb(1'b0, `IPD_ADDR_PWR_CFG, 32'h0, {28'h0, f, 2'b00}, 32'hF, 1'b0);
      // Both bits set, woken by each external pin in turn
      for (int i = 0; i < 2; i++)
      begin
         apb(1'b1, `IPD_ADDR_PWR_CFG, {28'h0, f, 2'b11}, 32'h0, 32'h0, 1'b0);
         wait_for(1'b1, 1'b0, 8);
         req <= 1'b1;
         repeat (6) @(posedge pclk);
         chk("osc_enable", 32'h0, {31'h0, osc_enable});
         req <= 1'b0;
         repeat (2) @(posedge pclk);
         if (i == 0)
            ext0 <= 1'b1;
         else
            ext1 <= 1'b1;
         wait_for(1'b1, 1'b1, 8);
         repeat ($urandom_range(3, 12)) @(posedge pclk);
         chk("cpu_clk_enable", 32'h0, {31'h0, cpu_clk_enable});
         ext0 <= 1'b0;
         ext1 <= 1'b0;
         wait_for(1'b0, 1'b1, 8);
         chk("cpu_wake_pulse", 32'h1, {31'h0, cpu_wake_pulse});
         apb(1'b0, `IPD_ADDR_PWR_CFG, 32'h0, {28'h0, f, 2'b00}, 32'hF, 1'b0);
      end
      // Keypad wake at each level, held off for the restart count
      for (int p = 0; p < 2; p++)
      begin
         key <= ~p[0];
         apb(1'b1, `IPD_ADDR_AUX_CTL, {30'h0, p[0], ~fuse}, 32'h0, 32'h0, 1'b0);
         apb(1'b1, `IPD_ADDR_PWR_CFG, 32'h2, 32'h0, 32'h0, 1'b0);
         wait_for(1'b1, 1'b0, 8);
         key <= p[0];
         wait_for(1'b1, 1'b1, 8);
         wait_for(1'b0, 1'b1, KEY + 8);
         chk("key wait", 32'h1, {31'h0, n >= KEY - 2 && n <= KEY + 4});
      end
      // Reset pin while stopped: clocks back at once, then the window
      for (int m = 1; m < 3; m++)
      begin
         apb(1'b1, `IPD_ADDR_PWR_CFG, 32'(m), 32'h0, 32'h0, 1'b0);
         wait_for(1'b0, 1'b0, 8);
         presetn <= 1'b0;
         #1;
         chk("clocks", 32'h7, {29'h0, osc_enable, cpu_clk_enable, per_clk_enable});
         repeat (4) @(posedge pclk);
         presetn <= 1'b1;
         n = 0;
         while (ram_block !== 1'b0 && n < 20)
         begin
            @(posedge pclk);
            n++;
         end
         chk("ram_block", 32'h1, {31'h0, ram_block === 1'b0 && n >= 4});
         apb(1'b0, `IPD_ADDR_PWR_CFG, 32'h0, 32'h0, 32'h3, 1'b0);
      end
      close_out();
   end
endmodule : testbench
`default_nettype wire
